// File: tsq_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tsq_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tsq_fifo

// File: tsq_pkg.sv
// Shared constants and types for the tape block transfer sequencer
package tsq_pkg;
  // ----------------------------------------------------------------
  // Word format
  // ----------------------------------------------------------------
  localparam int DIGIT_W = 4;
  localparam int WORD_DIGITS = 11;
  localparam int WORD_W = DIGIT_W * WORD_DIGITS;
  localparam int ADDR_W = 16;
  localparam int CNT_W = 8;
  localparam int SIGN_LSB = WORD_W - DIGIT_W;
  localparam int MODIFY_BIT = WORD_W - 1;
  localparam int FIFO_DEPTH = 8;
  // ----------------------------------------------------------------
  // Tape geometry in digit positions
  // ----------------------------------------------------------------
  localparam int FIRST_BLOCK_POS = 41;
  localparam int NEXT_BLOCK_POS = 80;
  localparam int POS_PER_WORD = 12;
  localparam int HEAD_STOP_POS = 60;
  localparam int START_GAP_POS = 119;
  localparam int ERASE_GAP_POS = 20;
  localparam int IBG_POS = 39;
  localparam int PB_FIRST_DEDUCT = START_GAP_POS + HEAD_STOP_POS + ERASE_GAP_POS + IBG_POS;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int POS_TIME_PS = 40000000;
  localparam int POS_CYC = POS_TIME_PS / CLK_PERIOD_PS;
  localparam int START_TIME_US = 5000;
  localparam int TURN_TIME_US = 5000;
  // Scaled in two steps so the product stays inside a 32-bit int
  localparam int START_CYC = START_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int TURN_CYC = TURN_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int TIMER_W = 24;
  localparam int POSCNT_W = 12;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_POS_BACK = 2'h2} tsq_op_t;
  typedef struct packed {
    tsq_op_t op;
    logic [CNT_W-1:0] words;
    logic [CNT_W-1:0] blocks;
    logic [ADDR_W-1:0] addr;
    logic index_en;
    logic [ADDR_W-1:0] index_val;
  } tsq_cmd_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [WORD_W-1:0] wdata;
  } tsq_mem_req_t;
endpackage

// File: tsq_sequencer.sv
// Tape block transfer sequencer: word/block loop, data path and motion timing
// Functional notes
// - Turn-around stops head within 60 positions
// - Turn-around modelled as 5 ms at most
// - First block: 41 plus 12 per word
// - Further blocks: 80 plus 12 per word
// - Position backward: 5 ms start and stop
// - Position backward assumes head 60 from end
// - Copy instruction image to control unit register
// - Preserve block start address in high field
// - Per word: address to storage, increment field
// - Read: tape word, buffer, index modify, store
// - Loop over words, then over blocks
// - Write: storage, buffer, adder, tape, low first
// - Recorded digits low first, sign last
`timescale 1ns/1ps
module tsq_sequencer #(
  parameter int START_CYCLES = tsq_pkg::START_CYC,
  parameter int TURN_CYCLES = tsq_pkg::TURN_CYC,
  parameter int POS_CYCLES = tsq_pkg::POS_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire tsq_pkg::tsq_cmd_t cmd,
  input wire logic [tsq_pkg::WORD_W-1:0] instr_image,
  input wire logic reread_req,
  output tsq_pkg::tsq_mem_req_t mem_req,
  input wire logic [tsq_pkg::WORD_W-1:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic [tsq_pkg::DIGIT_W-1:0] rx_digit,
  input wire logic rx_valid,
  output logic [tsq_pkg::DIGIT_W-1:0] tx_digit,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [tsq_pkg::WORD_W-1:0] tcu_instr,
  output logic tcu_instr_load,
  output logic tape_fwd,
  output logic tape_rev,
  output logic [7:0] head_margin,
  output logic busy,
  output logic done,
  output logic rx_overrun
);
  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_LOAD = 4'h1,
    S_START = 4'h3,
    S_PREP = 4'h2,
    S_ADDR = 4'h6,
    S_XFER = 4'h7,
    S_BEND = 4'h5,
    S_TURN = 4'h4,
    S_STOP = 4'hc,
    S_DONE = 4'hd
  } tsq_state_t;

  localparam int AW = tsq_pkg::ADDR_W;
  localparam int WW = tsq_pkg::WORD_W;
  localparam int PW = tsq_pkg::POSCNT_W;

  tsq_state_t state;
  tsq_pkg::tsq_cmd_t cmd_q;
  logic [AW-1:0] addr_field;
  logic [AW-1:0] addr_saved;
  logic [tsq_pkg::CNT_W-1:0] words_left;
  logic [tsq_pkg::CNT_W-1:0] blocks_left;
  logic first_block;
  logic [tsq_pkg::TIMER_W-1:0] timer;
  logic [PW-1:0] pos_left;
  logic [PW-1:0] next_pos;
  logic [15:0] pos_div;
  logic pos_tick;
  logic [WW-1:0] storage_buffer;
  logic have_word;
  logic [WW-1:0] rx_shift;
  logic [3:0] rx_count;
  logic rx_push;
  logic [WW-1:0] rx_word;
  logic fifo_in_valid;
  logic [WW-1:0] fifo_in_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WW-1:0] fifo_out_data;
  logic fifo_out_ready;
  logic ser_load_ready;
  logic is_read;
  logic is_write;
  logic moving;

  assign is_read = (cmd_q.op == tsq_pkg::OP_READ);
  assign is_write = (cmd_q.op == tsq_pkg::OP_WRITE);
  assign moving = tape_fwd || tape_rev;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Decimal count-up of the four-digit address field
  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (carry)
      begin
        if (r[i*4 +: 4] == 4'h9)
          r[i*4 +: 4] = 4'h0;
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // Positions the head covers over one block, per operation and block order
  always_comb
  begin
    next_pos = PW'(tsq_pkg::NEXT_BLOCK_POS) + PW'(tsq_pkg::POS_PER_WORD) * PW'(cmd_q.words);
    if (first_block)
    begin
      if (cmd_q.op == tsq_pkg::OP_POS_BACK)
      begin
        // Head starts near the end mark, so short blocks leave nothing to pass
        if (next_pos > PW'(tsq_pkg::PB_FIRST_DEDUCT))
          next_pos = next_pos - PW'(tsq_pkg::PB_FIRST_DEDUCT);
        else
          next_pos = '0;
      end
      else
        next_pos = PW'(tsq_pkg::FIRST_BLOCK_POS) + PW'(tsq_pkg::POS_PER_WORD) * PW'(cmd_q.words);
    end
  end

  // ----------------------------------------------------------------
  // Digit position timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || !moving || state == S_START || state == S_TURN || state == S_STOP)
    begin
      pos_div <= '0;
      pos_tick <= 1'b0;
    end
    else
    begin
      pos_tick <= (pos_div == 16'(POS_CYCLES - 1));
      pos_div <= (pos_div == 16'(POS_CYCLES - 1)) ? '0 : pos_div + 16'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pos_left <= '0;
    else if (state == S_PREP)
      pos_left <= next_pos;
    else if (pos_tick && pos_left != '0)
      pos_left <= pos_left - 1'b1;
  end

  // ----------------------------------------------------------------
  // Tape word assembly on read
  // ----------------------------------------------------------------
  // Digits arrive low first; shifting in at the top leaves the word aligned
  always_ff @(posedge clk)
  begin
    if (sys_rst || state == S_IDLE)
    begin
      rx_shift <= '0;
      rx_count <= '0;
      rx_push <= 1'b0;
      rx_word <= '0;
    end
    else
    begin
      rx_push <= 1'b0;
      if (rx_valid && is_read && busy)
      begin
        if (rx_count == 4'(tsq_pkg::WORD_DIGITS - 1))
        begin
          rx_word <= {rx_digit, rx_shift[WW-1:tsq_pkg::DIGIT_W]};
          rx_push <= 1'b1;
          rx_count <= '0;
        end
        else
        begin
          rx_shift <= {rx_digit, rx_shift[WW-1:tsq_pkg::DIGIT_W]};
          rx_count <= rx_count + 4'h1;
        end
      end
    end
  end

  // The drive cannot be held off, so a full FIFO loses the word
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rx_overrun <= 1'b0;
    else if (rx_push && !fifo_in_ready)
      rx_overrun <= 1'b1;
    // A loss in the same cycle as a new start is still reported
    else if (start)
      rx_overrun <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Buffer between tape side and storage side
  // ----------------------------------------------------------------
  assign fifo_in_valid = is_read ? rx_push : (state == S_XFER && is_write && have_word);
  assign fifo_in_data = is_read ? rx_word : storage_buffer;
  assign fifo_out_ready = is_read ? (state == S_XFER && !mem_req.wr) : ser_load_ready;

  tsq_fifo #(
    .WIDTH(WW),
    .DEPTH(tsq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(state == S_IDLE),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  tsq_word_ser u_ser (
    .clk(clk),
    .sys_rst(sys_rst),
    .load_valid(fifo_out_valid && is_write),
    .load_word(fifo_out_data),
    .load_ready(ser_load_ready),
    .digit(tx_digit),
    .digit_valid(tx_valid),
    .digit_ready(tx_ready)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= S_IDLE;
      cmd_q <= '0;
      timer <= '0;
      words_left <= '0;
      blocks_left <= '0;
      first_block <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (timer != '0)
        timer <= timer - 1'b1;
      case (state)
        S_IDLE:
          if (start)
          begin
            cmd_q <= cmd;
            state <= S_LOAD;
          end
        S_LOAD:
        begin
          first_block <= 1'b1;
          blocks_left <= cmd_q.blocks;
          timer <= tsq_pkg::TIMER_W'(START_CYCLES);
          state <= S_START;
        end
        S_START:
          if (timer == '0)
            state <= S_PREP;
        S_PREP:
        begin
          words_left <= (cmd_q.op == tsq_pkg::OP_POS_BACK) ? '0 : cmd_q.words;
          state <= S_ADDR;
        end
        S_ADDR:
          state <= (words_left == '0) ? S_BEND : S_XFER;
        S_XFER:
          if ((is_read && fifo_out_valid && !mem_req.wr) || (is_write && have_word && fifo_in_ready))
          begin
            words_left <= words_left - 1'b1;
            state <= S_ADDR;
          end
        S_BEND:
          if (pos_left == '0 && !fifo_out_valid && !tx_valid && ser_load_ready)
          begin
            first_block <= 1'b0;
            blocks_left <= blocks_left - 1'b1;
            if (blocks_left > 8'h1)
              state <= S_PREP;
            else if (cmd_q.op == tsq_pkg::OP_POS_BACK)
            begin
              timer <= tsq_pkg::TIMER_W'(START_CYCLES);
              state <= S_STOP;
            end
            else
            begin
              timer <= tsq_pkg::TIMER_W'(TURN_CYCLES);
              state <= S_TURN;
            end
          end
        S_TURN, S_STOP:
          if (timer == '0)
            state <= S_DONE;
        S_DONE:
        begin
          done <= 1'b1;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
      // An automatic retry restarts the block word loop
      if (reread_req && is_read && (state == S_ADDR || state == S_XFER || state == S_BEND))
        state <= S_PREP;
    end
  end

  // ----------------------------------------------------------------
  // Command register address field
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      addr_field <= '0;
      addr_saved <= '0;
    end
    else if (state == S_LOAD)
      addr_field <= cmd_q.addr;
    else if (reread_req && is_read && (state == S_ADDR || state == S_XFER || state == S_BEND))
      addr_field <= addr_saved;
    else if (state == S_PREP)
      addr_saved <= addr_field;
    else if (state == S_ADDR && words_left != '0)
      addr_field <= bcd_inc(addr_field);
  end

  // ----------------------------------------------------------------
  // Storage side
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mem_req <= '0;
      storage_buffer <= '0;
      have_word <= 1'b0;
    end
    else
    begin
      mem_req.rd <= 1'b0;
      mem_req.wr <= 1'b0;
      if (state == S_ADDR && words_left != '0)
      begin
        mem_req.addr <= addr_field;
        mem_req.rd <= is_write;
        have_word <= 1'b0;
      end
      if (state == S_XFER && is_read && fifo_out_valid && !mem_req.wr)
      begin
        storage_buffer <= fifo_out_data;
        mem_req.wdata <= fifo_out_data;
        if (cmd_q.index_en && fifo_out_data[tsq_pkg::MODIFY_BIT])
        begin
          // Modifier flag is consumed so the stored word carries it cleared
          mem_req.wdata[tsq_pkg::MODIFY_BIT] <= 1'b0;
          mem_req.wdata[AW-1:0] <= fifo_out_data[AW-1:0] + cmd_q.index_val;
        end
        mem_req.wr <= 1'b1;
      end
      if (state == S_XFER && is_write && !have_word && mem_rvalid)
      begin
        storage_buffer <= mem_rdata;
        have_word <= 1'b1;
      end
      else if (state == S_XFER && is_write && have_word && fifo_in_ready)
        have_word <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control unit and motion outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tcu_instr <= '0;
      tcu_instr_load <= 1'b0;
    end
    else
    begin
      tcu_instr_load <= (state == S_LOAD);
      if (state == S_LOAD)
        tcu_instr <= instr_image;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tape_fwd <= 1'b0;
      tape_rev <= 1'b0;
      busy <= 1'b0;
      head_margin <= '0;
    end
    else
    begin
      busy <= (state != S_IDLE) && (state != S_DONE);
      tape_fwd <= (state inside {S_START, S_PREP, S_ADDR, S_XFER, S_BEND}) && cmd_q.op != tsq_pkg::OP_POS_BACK;
      tape_rev <= (state inside {S_START, S_PREP, S_ADDR, S_XFER, S_BEND, S_STOP} && cmd_q.op == tsq_pkg::OP_POS_BACK)
        || (state == S_TURN && timer > tsq_pkg::TIMER_W'(TURN_CYCLES / 2));
      // The stop after reversal leaves the head inside the last block
      if (state == S_TURN && timer == '0)
        head_margin <= 8'(tsq_pkg::HEAD_STOP_POS);
      else if (state == S_LOAD)
        head_margin <= (cmd_q.op == tsq_pkg::OP_POS_BACK) ? 8'(tsq_pkg::HEAD_STOP_POS) : '0;
    end
  end
endmodule // tsq_sequencer

// File: tsq_sequencer_asserts.sv
// Port-level concurrent checks for the tape block transfer sequencer
`timescale 1ns/1ps
module tsq_sequencer_asserts #(
  parameter int START_CYCLES = 20,
  parameter int TURN_CYCLES = 20,
  parameter int POS_CYCLES = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire tsq_pkg::tsq_mem_req_t mem_req,
  input wire logic [tsq_pkg::DIGIT_W-1:0] tx_digit,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tcu_instr_load,
  input wire logic tape_fwd,
  input wire logic tape_rev,
  input wire logic [7:0] head_margin,
  input wire logic busy,
  input wire logic done
);
  // Stopping after reverse motion may span half a turn interval
  localparam int DONE_MAX = START_CYCLES + TURN_CYCLES + POS_CYCLES;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_load_after_start: assert property (start && !busy && !done |-> ##2 tcu_instr_load)
    else $error("instruction load not two cycles after start");
  a_load_one_cycle: assert property (tcu_instr_load |=> !tcu_instr_load)
    else $error("instruction load longer than one cycle");
  a_dir_exclusive: assert property (!(tape_fwd && tape_rev))
    else $error("tape driven both ways at once");
  a_motion_while_busy: assert property (tape_fwd || tape_rev |-> busy)
    else $error("tape moving while idle");
  // The stop interval ends in the same cycle as the completion pulse
  a_reverse_then_done: assert property ($fell(tape_rev) |-> ##[0:DONE_MAX] done)
    else $error("no completion after reverse motion");
  a_margin_at_done: assert property (done |-> head_margin != 8'h00 && head_margin <= 8'h3c)
    else $error("head margin outside limit at completion");
  a_done_pulse: assert property (done |=> !done)
    else $error("completion pulse too long");
  a_mem_exclusive: assert property (!(mem_req.rd && mem_req.wr))
    else $error("storage read and write together");
  a_write_pulse: assert property (mem_req.wr |=> !mem_req.wr)
    else $error("storage write longer than one cycle");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_digit))
    else $error("tape digit changed while stalled");
  cover property (done);
  cover property (mem_req.wr);
  cover property (tx_valid && !tx_ready);
  cover property (tape_rev && head_margin == 8'h3c);
endmodule // tsq_sequencer_asserts

bind tsq_sequencer tsq_sequencer_asserts #(.START_CYCLES(START_CYCLES), .TURN_CYCLES(TURN_CYCLES),
  .POS_CYCLES(POS_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst), .start(start), .mem_req(mem_req),
  .tx_digit(tx_digit), .tx_valid(tx_valid), .tx_ready(tx_ready), .tcu_instr_load(tcu_instr_load),
  .tape_fwd(tape_fwd), .tape_rev(tape_rev), .head_margin(head_margin), .busy(busy), .done(done));

// File: tsq_sequencer_test.sv
// Self-checking testbench for the tape block transfer sequencer
`timescale 1ns/1ps
module tsq_sequencer_test;
  localparam int ST = 20;
  localparam int TN = 20;
  localparam int PC = 4;
  logic clk, sys_rst, start, reread_req, mem_rvalid, rx_valid, tx_valid, tx_ready, slow;
  logic tcu_instr_load, tape_fwd, tape_rev, busy, done, rx_overrun, saw_fwd, margin_bad;
  tsq_pkg::tsq_cmd_t cmd;
  tsq_pkg::tsq_mem_req_t mem_req;
  logic [tsq_pkg::WORD_W-1:0] instr_image, mem_rdata, tcu_instr, load_img;
  logic [tsq_pkg::DIGIT_W-1:0] rx_digit, tx_digit;
  logic [7:0] head_margin;
  int bad_count, n_compared, n_loads;
  tsq_sequencer #(.START_CYCLES(ST), .TURN_CYCLES(TN), .POS_CYCLES(PC)) uut (.clk(clk), .sys_rst(sys_rst),
    .start(start), .cmd(cmd), .instr_image(instr_image), .reread_req(reread_req), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .rx_digit(rx_digit), .rx_valid(rx_valid),
    .tx_digit(tx_digit), .tx_valid(tx_valid), .tx_ready(tx_ready), .tcu_instr(tcu_instr),
    .tcu_instr_load(tcu_instr_load), .tape_fwd(tape_fwd), .tape_rev(tape_rev), .head_margin(head_margin),
    .busy(busy), .done(done), .rx_overrun(rx_overrun));
  tsq_tape_model model (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .tape_fwd(tape_fwd), .rx_digit(rx_digit), .rx_valid(rx_valid),
    .tx_digit(tx_digit), .tx_valid(tx_valid), .tx_ready(tx_ready));
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (tcu_instr_load)
      n_loads++;
    if (tcu_instr_load)
      load_img = tcu_instr;
    if (tape_fwd)
      saw_fwd = 1'b1;
    if (tape_rev && head_margin !== 8'h3c)
      margin_bad = 1'b1;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A second start mid-run must be ignored; run time bounded below by the tape figures
  task automatic go(input tsq_pkg::tsq_op_t op, input int w, input int b, input logic [15:0] a, input int lo);
    int cyc;
    @(negedge clk);
    {n_loads, saw_fwd, margin_bad, cyc} = '0;
    cmd = '{op: op, words: w[7:0], blocks: b[7:0], addr: a, index_en: 1'b1, index_val: 16'h0123};
    start = 1'b1;
    @(negedge clk);
    while (done !== 1'b1 && cyc < 4000)
    begin
      start = (cyc == 40);
      @(negedge clk);
      cyc++;
    end
    start = 1'b0;
    check("done", done, 1'b1);
    check("run length", cyc >= lo && cyc <= lo + 30 * b + 30, 1'b1);
    check("loads", n_loads, 1);
    check("instr copy", load_img, instr_image);
    check("overrun", rx_overrun, 1'b0);
  endtask
  task automatic load_tape(input logic [43:0] w0, input logic [43:0] w1);
    model.tape[0] = w0;
    model.tape[1] = w1;
    model.n_tape = 2;
    model.rd_ptr = 0;
    model.dig = 0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("reset outs", {busy, done, tape_fwd, tape_rev, tcu_instr_load, tx_valid, mem_req.rd, mem_req.wr}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_read_one;
    load_tape(44'h09876543210, 44'h80000001000);
    go(tsq_pkg::OP_READ, 2, 1, 16'h0098, ST + 65 * PC + TN);
    check("word 0098", model.mem[8'h98], 44'h09876543210);
    check("word 0099 indexed", model.mem[8'h99], 44'h00000001123);
    $display("test read one block done");
  endtask
  task automatic t_read_two;
    load_tape(44'h01020304050, 44'h06070809000);
    model.n_tape = 1;
    fork
      go(tsq_pkg::OP_READ, 1, 2, 16'h0099, ST + 145 * PC + TN);
      // The second block only reaches the head after the first has passed
      begin
        repeat (ST + 60 * PC) @(negedge clk);
        model.n_tape = 2;
      end
    join
    check("word 0099", model.mem[8'h99], 44'h01020304050);
    check("word 0100", model.mem[8'h00], 44'h06070809000);
    check("no binary step", model.mem[8'h9a], 44'h00000000000);
    $display("test read two blocks done");
  endtask
  task automatic t_reread;
    load_tape(44'h05555555555, 44'h06666666666);
    fork
      go(tsq_pkg::OP_READ, 2, 1, 16'h0050, 77 + ST + 65 * PC + TN);
      // Retry while the block end is awaited; the drive replays it with fresh data
      begin
        repeat (100) @(negedge clk);
        reread_req = 1'b1;
        load_tape(44'h01111111111, 44'h02222222222);
        @(negedge clk);
        reread_req = 1'b0;
      end
    join
    check("retry 0050", model.mem[8'h50], 44'h01111111111);
    check("retry 0051", model.mem[8'h51], 44'h02222222222);
    check("retry 0052", model.mem[8'h52], 44'h00000000000);
    $display("test re-read done");
  endtask
  task automatic t_write;
    logic [43:0] w [2];
    w[0] = 44'h31234567890;
    w[1] = 44'h29876543210;
    model.mem[8'h40] = w[0];
    model.mem[8'h41] = w[1];
    model.sent.delete();
    model.n_tape = 0;
    slow = 1'b1;
    go(tsq_pkg::OP_WRITE, 2, 1, 16'h0040, ST + 65 * PC + TN);
    slow = 1'b0;
    check("digit count", model.sent.size(), 22);
    for (int i = 0; i < 22 && i < model.sent.size(); i++)
      check("tx digit", model.sent[i], w[i / 11][(i % 11) * 4 +: 4]);
    $display("test write done");
  endtask
  task automatic t_posback;
    go(tsq_pkg::OP_POS_BACK, 20, 1, 16'h0000, ST + 82 * PC + ST);
    check("no forward", saw_fwd, 1'b0);
    check("margin in reverse", margin_bad, 1'b0);
    $display("test position backward done");
  endtask
  initial
  begin
    {clk, start, reread_req, slow, bad_count, n_compared} = '0;
    sys_rst = 1'b1;
    cmd = '0;
    instr_image = 44'h15004200731;
    repeat (16) @(negedge clk);
    t_reset();
    sys_rst = 1'b0;
    t_read_one();
    t_read_two();
    t_reread();
    t_write();
    t_posback();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule // tsq_sequencer_test

// File: tsq_tape_model.sv
// Storage and tape drive model facing the sequencer
`timescale 1ns/1ps
module tsq_tape_model (
  input wire logic clk,
  input wire logic slow,
  input wire tsq_pkg::tsq_mem_req_t mem_req,
  output logic [tsq_pkg::WORD_W-1:0] mem_rdata,
  output logic mem_rvalid,
  input wire logic tape_fwd,
  output logic [tsq_pkg::DIGIT_W-1:0] rx_digit,
  output logic rx_valid,
  input wire logic [tsq_pkg::DIGIT_W-1:0] tx_digit,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [tsq_pkg::WORD_W-1:0] mem [0:255];
  logic [tsq_pkg::WORD_W-1:0] tape [0:7];
  logic [tsq_pkg::DIGIT_W-1:0] sent [$];
  logic [7:0] rd_addr;
  logic phase;
  int n_tape;
  int rd_ptr;
  int dig;
  int lat;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = '0;
    {phase, rd_addr, mem_rdata, mem_rvalid, rx_digit, rx_valid, tx_ready} = '0;
    {n_tape, rd_ptr, dig, lat} = '0;
  end
  // Undriven data lines toggle so a stale value never looks valid
  always @(posedge clk)
  begin
    phase <= ~phase;
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    rx_valid <= 1'b0;
    rx_digit <= ~rx_digit;
    tx_ready <= !slow || phase;
    if (mem_req.wr)
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
    if (mem_req.rd)
    begin
      rd_addr <= mem_req.addr[7:0];
      lat <= slow ? 3 : 1;
    end
    else if (lat > 1)
      lat <= lat - 1;
    else if (lat == 1)
    begin
      lat <= 0;
      mem_rvalid <= 1'b1;
      mem_rdata <= mem[rd_addr];
    end
    if (tx_valid && tx_ready)
      sent.push_back(tx_digit);
    if (tape_fwd && phase && rd_ptr < n_tape)
    begin
      rx_valid <= 1'b1;
      rx_digit <= tape[rd_ptr][dig*4 +: 4];
      dig <= (dig == 10) ? 0 : dig + 1;
      if (dig == 10)
        rd_ptr <= rd_ptr + 1;
    end
  end
endmodule // tsq_tape_model

// File: tsq_word_ser.sv
// Word to digit serializer, least significant digit first, sign last
`timescale 1ns/1ps
module tsq_word_ser (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load_valid,
  input wire logic [tsq_pkg::WORD_W-1:0] load_word,
  output logic load_ready,
  output logic [tsq_pkg::DIGIT_W-1:0] digit,
  output logic digit_valid,
  input wire logic digit_ready
);
  logic [tsq_pkg::WORD_W-1:0] shift;
  logic [3:0] left;

  assign load_ready = (left == '0) && !digit_valid;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      shift <= '0;
      left <= '0;
      digit <= '0;
      digit_valid <= 1'b0;
    end
    else if (load_valid && load_ready)
    begin
      shift <= load_word;
      left <= 4'(tsq_pkg::WORD_DIGITS);
    end
    else if (!digit_valid || digit_ready)
    begin
      digit_valid <= (left != '0);
      if (left != '0)
      begin
        // Low digit goes first so the sign digit closes the word on tape
        digit <= shift[tsq_pkg::DIGIT_W-1:0];
        shift <= shift >> tsq_pkg::DIGIT_W;
        left <= left - 1'b1;
      end
    end
  end
endmodule // tsq_word_ser
